// >>> dv/elr_mem_model.sv
/* Memory at the far side: fetch words and data-cache operands.
 Assumes combinational reads and contents fixed at time zero. */
`timescale 1ns/100ps
module elr_mem_model (
    input  wire logic [31:0] fetchAddr,    // Fetch address
    input  wire logic [31:0] accAddr,      // Data piece address
    output logic      [31:0] fetchMemWord, // Word as stored
    output logic      [31:0] cacheOpData   // Operand, first byte in 31:24
);
    logic [31:0] mem [16]; // Stored words, never swapped here
    // Region 1 already holds its image in the new order
    initial mem = '{0: 32'h7ce72214, 1: 32'h1422e77c, 2: 32'h11223344,
                    3: 32'h55667788, default: 32'h0};
    // Rotate, not shift: low lanes keep stale bytes, never zeros
    assign fetchMemWord = mem[fetchAddr[5:2]];
    assign cacheOpData  = 32'({2{mem[accAddr[5:2]]}} >> (32 - 8 * int'(accAddr[1:0])));
endmodule // elr_mem_model

// >>> dv/tb_top.sv
/* Bench of the byte-lane steering block: AHB, fetch and data-piece tasks.
 Expected values are worked out here; assumes elr_mem_model as memory. */
`timescale 1ns/100ps
module tb_top import elr_pkg::*; ;
    logic        clk_sys, nrst, hwrite, hreadyout, fetchValid, fetchTlbOrder;
    logic        fillValid, fetchOrder, accValid, accFirst, accLast, accStore;
    logic        accByteRev, accNeedAlign, accTlbOrder, dataOrder, misaligned;
    logic        alignFault, loadValid, storeValid;         // Result strobes
    logic [1:0]  htrans, hresp, accSize;                    // Bus codes, size
    logic [2:0]  hsize;                                     // Always a word
    logic [31:0] haddr, hwdata, hrdata, fetchAddr, fetchMemWord, fillAddr, fillWord;
    logic [31:0] accAddr, cacheOpData, regStoreData, memAddr, loadData, storeData;
    int          failures, cmp_count;                       // Tallies
    elr_top DUT (.hsel(1'b1), .hready(hreadyout), .*);
    elr_mem_model MEM (.*);
    // Core clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Compare one value, report a difference at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) failures++;
        if (seen !== exp) $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    // Single AHB word; on reads d is the expected word, taken at the closing edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) {haddr, hwrite, htrans} <= {24'h0, a, w, 2'b10};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        {htrans, hwdata} <= {HTRANS_IDLE, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        if (!w) chk(hrdata, d);
        chk({hreadyout, hresp}, {1'b1, HRESP_OKAY});     // Bus answer always OKAY
    endtask
    // One fetch word; fill results land one cycle later
    task automatic fet(input logic [31:0] a, input logic t, input logic [31:0] w, input logic o);
        @(posedge clk_sys) {fetchValid, fetchAddr, fetchTlbOrder} <= {1'b1, a, t};
        @(posedge clk_sys) fetchValid <= 1'b0;
        #1;
        chk(fillWord, w);
        chk(fillAddr, {a[31:2], 2'h0});
        chk({fillValid, fetchOrder}, {1'b1, o});
    endtask
    // One data piece; ex is the register value loaded or memory-order value stored
    task automatic acc(input logic [31:0] a, input elr_size_e sz, input logic [31:0] ex,
        input logic o, m, st = 0, br = 0, nd = 1, t = 0, input logic [1:0] fl = 2'h3);
        @(posedge clk_sys) {accValid, accFirst, accLast, accStore, accByteRev} <= {1'b1, fl, st, br};
        {accNeedAlign, accTlbOrder, accAddr, accSize} <= {nd, t, a, sz};
        @(posedge clk_sys) accValid <= 1'b0;
        #1;
        chk(st ? storeData : loadData, ex);
        chk(memAddr, a);
        chk({st ? storeValid : loadValid, dataOrder, misaligned, alignFault},
            {1'b1, o, m, m & nd});
    endtask
    // Verdict, the one place the run ends
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys); // Tests need well under 1000 cycles
        failures++;
        complete_run();
    end
    // Reset, registers, fetches, loads, stores, modes, split access
    initial begin
        {nrst, hwrite, fetchValid, fetchTlbOrder, accValid, accFirst, accLast} = '0;
        {accStore, accByteRev, accNeedAlign, accTlbOrder, htrans, accSize} = '0;
        {haddr, hwdata, fetchAddr, accAddr, failures, cmp_count} = '0;
        {hsize, regStoreData} = {3'h2, 32'haabbccdd};
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ahb(0, OFS_MSW, 32'h0);
        ahb(0, 8'h0c, 32'h0);                                     // Unmapped reads zero
        fet(32'h00000000, 1, 32'h7ce72214, 0);
        ahb(1, OFS_ORDER_MAP, 32'h2);                             // Region 1 little
        ahb(0, OFS_ORDER_MAP, 32'h2);
        fet(32'h08000006, 0, 32'h7ce72214, 1);
        acc(32'h08000008, SZ_HALF, 32'h2211, 1, 0);
        acc(32'h0800000a, SZ_HALF, 32'h4433, 1, 0);
        acc(32'h08000008, SZ_WORD, 32'h44332211, 1, 0);
        acc(32'h08000009, SZ_WORD, 32'h11443322, 1, 1);
        acc(32'h08000009, SZ_BYTE, 32'h00000022, 1, 0);
        acc(32'h00000008, SZ_WORD, 32'h44332211, 0, 0, 0, 1);
        acc(32'h0000000c, SZ_DWORD, 32'h55667788, 0, 1);
        acc(32'h08000008, SZ_WORD, 32'hddccbbaa, 1, 0, 1);
        acc(32'h0800000a, SZ_HALF, 32'hddcc0000, 1, 0, 1);
        acc(32'h0800000b, SZ_BYTE, 32'hdd000000, 1, 0, 1);
        acc(32'h00000008, SZ_HALF, 32'hccdd0000, 0, 0, 1);
        ahb(1, OFS_MSW, 32'h1);                                   // Fetch relocate only
        fet(32'h00000004, 1, 32'h7ce72214, 1);
        acc(32'h00000008, SZ_WORD, 32'h44332211, 1, 0, 0, 0, 1, 1);
        ahb(1, OFS_MSW, 32'h0);                                   // Back to real mode
        acc(32'h08000008, SZ_WORD, 32'h44332211, 1, 0, 0, 0, 1, 0, 2'h2);
        acc(32'h0000000c, SZ_WORD, 32'h88776655, 1, 0, 0, 0, 1, 0, 2'h1);
        ahb(0, OFS_STATUS, 32'h3);
        complete_run();
    end
endmodule // tb_top

// >>> hw/elr_lane_swap.sv
/*
 Lane-swap stage between the data cache and the general registers.
 Assumes memory-order operands are left-justified, first address in bits 31:24,
 and register values are right-justified. Doublewords arrive as word pieces.
*/
`timescale 1ns/100ps
module elr_lane_swap
    import elr_pkg::*;
#(
    parameter bit TO_REG = 1'b1    // 1: load direction, 0: store direction
)(
    input  wire logic clk_sys,     // Core clock
    input  wire logic rstN,        // Synchronised reset, active low
    elr_swap_if.lane  sw           // Operand in and out
);
    logic [31:0] next_data;        // Steered operand before the register

    // Size decides the lanes; reverse flips bytes inside the operand only
    always_comb begin
        next_data = '0;
        case (sw.size)
            SZ_BYTE: begin         // Single byte never moves, see RULE8
                next_data = TO_REG ? {24'h0, sw.dataIn[31:24]} : {sw.dataIn[7:0], 24'h0};
            end
            SZ_HALF: begin         // Swap inside halfword only, see RULE9
                if (TO_REG) begin
                    next_data = sw.reverse ? {16'h0, sw.dataIn[23:16], sw.dataIn[31:24]}
                                           : {16'h0, sw.dataIn[31:16]};
                end else begin
                    next_data = sw.reverse ? {sw.dataIn[7:0], sw.dataIn[15:8], 16'h0}
                                           : {sw.dataIn[15:0], 16'h0};
                end
            end
            default: begin         // Word pieces, full reversal, see RULE10
                next_data = sw.reverse ? elr_rev4(sw.dataIn) : sw.dataIn;
            end
        endcase
    end

    // Output stage keeps data off the combinational path
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            sw.dataOut  <= '0;
            sw.validOut <= 1'b0;
        end else begin
            sw.dataOut  <= next_data;
            sw.validOut <= sw.valid;
        end
    end
endmodule // elr_lane_swap

// >>> hw/elr_pkg.sv
/*
 Constants, types and helper functions of the byte-lane steering block.
 Assumes a 32-bit core datapath, one core clock and an AHB-Lite register bus.
*/
// Overview of operation
// RULE1: Tag every fetch, load and store with order.
// RULE2: Any relocate bit set: order from translation entry.
// RULE3: Both relocate bits clear: order from region map.
// RULE4: Little-endian never changes the access address.
// RULE5: Little-endian fetch words reversed before instruction cache.
// RULE6: Instruction cache always holds big-endian words.
// RULE7: Data reversal sits between data cache and registers.
// RULE8: Byte operands are never reordered.
// RULE9: Little-endian halfwords swap their two bytes.
// RULE10: Little-endian words reverse all four bytes.
// RULE11: Normal big-endian: high register byte at low address.
// RULE12: Byte-reversing access: high register byte at high address.
// RULE13: Aligned only at multiple of operand length.
// RULE14: Alignment judged on low four address bits.
// RULE15: Instructions are words on word boundaries.
// RULE16: Order flag never changes alignment handling.
// RULE17: Big-endian alignment faults apply equally to little-endian.
// RULE18: Software invalidates instruction cache after order change.
// RULE19: Fetch and data relocate bits choose mode independently. The code does not: either bit selects the entry order for both fetch and data.
// RULE20: Split access keeps order sampled at its start.
package elr_pkg;
    localparam int unsigned DATA_W         = 32;          // Datapath width
    localparam int unsigned RADDR_W        = 8;           // Decoded register address bits
    localparam logic [7:0]  OFS_MSW        = 8'h00;       // machine_state_word
    localparam logic [7:0]  OFS_ORDER_MAP  = 8'h04;       // real_mode_order_map
    localparam logic [7:0]  OFS_STATUS     = 8'h08;       // Read-only status
    localparam int unsigned MSW_FETCH_RELOC = 0;          // fetch_relocate bit
    localparam int unsigned MSW_DATA_RELOC  = 1;          // data_relocate bit
    localparam logic [1:0]  MSW_RESET      = 2'h0;        // Real mode after reset
    localparam logic [31:0] ORDER_MAP_RESET = 32'h0;      // All regions big-endian
    localparam int unsigned REGION_MSB     = 31;          // Region index, top address bits
    localparam int unsigned REGION_LSB     = 27;
    localparam int unsigned ST_FETCH_ORDER = 0;           // Status bit positions
    localparam int unsigned ST_DATA_ORDER  = 1;
    localparam int unsigned ST_MISALIGN    = 2;
    localparam int unsigned ST_ALIGN_FAULT = 3;
    localparam int unsigned ST_SPLIT_BUSY  = 4;
    localparam logic        ORDER_BIG      = 1'b0;        // Flag value 0
    localparam logic        ORDER_LITTLE   = 1'b1;        // Flag value 1
    localparam logic [1:0]  HTRANS_IDLE    = 2'b00;
    localparam logic [1:0]  HRESP_OKAY     = 2'b00;

    // Operand sizes
    typedef enum logic [1:0] {
        SZ_BYTE  = 2'b00,
        SZ_HALF  = 2'b01,
        SZ_WORD  = 2'b10,
        SZ_DWORD = 2'b11
    } elr_size_e;

    // Split-access tracker states
    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_HELD = 1'b1
    } elr_acc_e;

    // Address bits that must be zero for an aligned operand
    function automatic logic [3:0] elr_align_mask(input elr_size_e sz);
        case (sz)
            SZ_BYTE:  elr_align_mask = 4'h0;
            SZ_HALF:  elr_align_mask = 4'h1;
            SZ_WORD:  elr_align_mask = 4'h3;
            default:  elr_align_mask = 4'h7;
        endcase
    endfunction

    // Reverse the four bytes of a word
    function automatic logic [31:0] elr_rev4(input logic [31:0] w);
        elr_rev4 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
endpackage

// >>> hw/elr_swap_if.sv
/*
 Interface carrying one operand into and out of a lane-swap stage.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/100ps
interface elr_swap_if;
    import elr_pkg::*;
    logic        valid;      // Operand present
    elr_size_e   size;       // Operand size
    logic        reverse;    // Reverse bytes within operand
    logic [31:0] dataIn;     // Operand before steering
    logic        validOut;   // Steered operand present
    logic [31:0] dataOut;    // Steered operand, registered

    modport drv  (output valid, size, reverse, dataIn, input validOut, dataOut);
    modport lane (input valid, size, reverse, dataIn, output validOut, dataOut);
endinterface

// >>> hw/elr_top.sv
/*
 Byte-lane steering of the core: order flag selection, fetch word reversal,
 load/store lane steering, alignment classification and an AHB-Lite slave.
 Assumes the translation lookup, both caches and exception dispatch sit outside,
 all on clk_sys; split accesses are marked first/last by the load/store unit.
*/
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module elr_top
    import elr_pkg::*;
#(
    parameter int unsigned REGIONS = 32      // Regions in the order map
)(
    input  wire logic        clk_sys,        // Core clock, 100 MHz
    input  wire logic        nrst,           // Async reset, active low
    input  wire logic        hsel,           // AHB slave select
    input  wire logic [31:0] haddr,          // AHB address
    input  wire logic [1:0]  htrans,         // AHB transfer type
    input  wire logic        hwrite,         // AHB write
    input  wire logic [2:0]  hsize,          // AHB size, words only
    input  wire logic [31:0] hwdata,         // AHB write data
    input  wire logic        hready,         // AHB bus ready
    output logic      [31:0] hrdata,         // AHB read data
    output logic             hreadyout,      // AHB slave ready
    output logic      [1:0]  hresp,          // AHB response
    input  wire logic        fetchValid,     // Fetch word from memory present
    input  wire logic [31:0] fetchAddr,      // Fetch address
    input  wire logic        fetchTlbOrder,  // Order field of matching entry
    input  wire logic [31:0] fetchMemWord,   // Word as stored in memory
    output logic             fillValid,      // Fill word for instruction_cache
    output logic      [31:0] fillAddr,       // Word-aligned fill address
    output logic      [31:0] fillWord,       // Big-endian instruction word
    output logic             fetchOrder,     // Order flag of the fetch
    input  wire logic        accValid,       // Data access piece present
    input  wire logic        accFirst,       // First piece of an access
    input  wire logic        accLast,        // Last piece of an access
    input  wire logic [31:0] accAddr,        // Piece address
    input  wire logic [1:0]  accSize,        // Operand size code
    input  wire logic        accStore,       // Store when high
    input  wire logic        accByteRev,     // Byte-reversing instruction
    input  wire logic        accNeedAlign,   // Instruction faults when misaligned
    input  wire logic        accTlbOrder,    // Order field of matching entry
    input  wire logic [31:0] cacheOpData,    // Load operand from data_cache
    input  wire logic [31:0] regStoreData,   // Store value from general_register
    output logic      [31:0] memAddr,        // Address towards data_cache
    output logic             dataOrder,      // Order flag of the access
    output logic             misaligned,     // Operand misaligned
    output logic             alignFault,     // Alignment exception request
    output logic             loadValid,      // Load result present
    output logic      [31:0] loadData,       // Value for general_register
    output logic             storeValid,     // Store operand present
    output logic      [31:0] storeData       // Memory-order store operand
);
    // One order bit per region, indexed by the top address bits
    // Refused at elaboration: the map width is tied to the region index bits
    if (REGIONS != 32) begin : g_regions_check
        $error("REGIONS must match address bits 31:27");
    end

    logic        rstMeta;                    // Reset synchroniser, first stage
    logic        rstN;                       // Reset used by the whole block
    logic [1:0]  msw;                        // machine_state_word relocate bits
    logic [31:0] orderMap;                   // real_mode_order_map
    logic [4:0]  status;                     // Last seen block state
    logic [1:0]  next_msw;                   // Register values after this cycle
    logic [31:0] next_orderMap;
    logic        wrPend;                     // Write data phase pending
    logic [7:0]  wrAddr;                     // Address of pending write
    logic        busTake;                    // Address phase accepted
    logic        virtMode;                   // Any relocate bit set
    logic        fetchOrderNow;              // Order for current fetch
    logic        accOrderNow;                // Order for current piece
    logic        accOrderHeld;               // Order sampled at access start
    elr_acc_e    accState;                   // Split-access tracker
    logic        misNow;                     // Current piece misaligned
    elr_size_e   sizeNow;                    // Size code as enum

    // Reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // Zero wait states, always OKAY; hsize is not checked, words only
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign busTake   = hsel && hready && htrans[1];

    // Address phase of a write is held for its data phase
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wrPend <= 1'b0;
            wrAddr <= '0;
        end else begin
            wrPend <= busTake && hwrite;
            wrAddr <= haddr[RADDR_W-1:0];
        end
    end

    // Next register values, also used to forward a write to a following read
    always_comb begin
        next_msw      = msw;
        next_orderMap = orderMap;
        if (wrPend && (wrAddr == OFS_MSW)) begin
            next_msw = hwdata[1:0];
        end
        if (wrPend && (wrAddr == OFS_ORDER_MAP)) begin
            next_orderMap = hwdata;
        end
    end

    // Software-written registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            msw      <= MSW_RESET;
            orderMap <= ORDER_MAP_RESET;
        end else begin
            msw      <= next_msw;
            orderMap <= next_orderMap;
        end
    end

    // Read data registered in the address phase; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            hrdata <= '0;
        end else if (busTake && !hwrite) begin
            case (haddr[RADDR_W-1:0])
                OFS_MSW:       hrdata <= {30'h0, next_msw};
                OFS_ORDER_MAP: hrdata <= next_orderMap;
                OFS_STATUS:    hrdata <= {27'h0, status};
                default:       hrdata <= '0;
            endcase
        end
    end

    // Either relocate bit puts the flag source on the translation entry
    assign virtMode = msw[MSW_FETCH_RELOC] || msw[MSW_DATA_RELOC];   // see RULE19

    // Fetch order: entry field in virtual mode, region map in real mode
    assign fetchOrderNow = virtMode ? fetchTlbOrder                  // see RULE2
                                    : orderMap[fetchAddr[REGION_MSB:REGION_LSB]]; // see RULE3

    // Fill path: reverse little-endian words so the cache only sees big-endian
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            fillValid  <= 1'b0;
            fillAddr   <= '0;
            fillWord   <= '0;
            fetchOrder <= ORDER_BIG;
        end else begin
            fillValid  <= fetchValid;
            if (fetchValid) begin
                fetchOrder <= fetchOrderNow;                          // see RULE1
                fillAddr   <= {fetchAddr[31:2], 2'b00};               // see RULE15
                fillWord   <= (fetchOrderNow == ORDER_LITTLE) ?
                              elr_rev4(fetchMemWord) : fetchMemWord;  // see RULE5, see RULE6
            end
        end
    end

    // Split tracker; a piece after the first reuses the flag of the first
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            accState     <= ACC_IDLE;
            accOrderHeld <= ORDER_BIG;
        end else if (accValid) begin
            if (accFirst) begin
                accOrderHeld <= virtMode ? accTlbOrder
                                         : orderMap[accAddr[REGION_MSB:REGION_LSB]];
            end
            case (accState)
                ACC_IDLE: accState <= (accFirst && !accLast) ? ACC_HELD : ACC_IDLE;
                ACC_HELD: accState <= accLast ? ACC_IDLE : ACC_HELD;
                default:  accState <= ACC_IDLE;
            endcase
        end
    end

    // Flag for this piece: fresh at start, held while a split is open
    always_comb begin
        if (accFirst || accState == ACC_IDLE) begin
            accOrderNow = virtMode ? accTlbOrder                     // see RULE2
                                   : orderMap[accAddr[REGION_MSB:REGION_LSB]]; // see RULE3
        end else begin
            accOrderNow = accOrderHeld;                              // see RULE20
        end
    end

    // Alignment from the low four address bits; flag plays no part
    assign sizeNow = elr_size_e'(accSize);
    assign misNow  = |(accAddr[3:0] & elr_align_mask(sizeNow));       // see RULE13, see RULE14

    // Address passes unchanged; fault depends only on low address bits, size and instruction
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memAddr    <= '0;
            dataOrder  <= ORDER_BIG;
            misaligned <= 1'b0;
            alignFault <= 1'b0;
        end else if (accValid) begin
            memAddr    <= accAddr;                                    // see RULE4
            dataOrder  <= accOrderNow;                                // see RULE1
            misaligned <= misNow;                                     // see RULE16
            alignFault <= misNow && accNeedAlign;                     // see RULE17
        end else begin
            alignFault <= 1'b0;
        end
    end

    // Lane steering: reverse when little-endian xor byte-reversing form
    elr_swap_if ldIf ();
    elr_swap_if stIf ();

    assign ldIf.valid   = accValid && !accStore;
    assign ldIf.size    = sizeNow;
    assign ldIf.reverse = accOrderNow ^ accByteRev;                   // see RULE11, see RULE12
    assign ldIf.dataIn  = cacheOpData;                                // see RULE7
    assign stIf.valid   = accValid && accStore;
    assign stIf.size    = sizeNow;
    assign stIf.reverse = accOrderNow ^ accByteRev;                   // see RULE11, see RULE12
    assign stIf.dataIn  = regStoreData;                               // see RULE7

    // Load direction: memory order to register value
    elr_lane_swap #(
        .TO_REG (1'b1)
    ) u_load (
        .clk_sys (clk_sys),
        .rstN    (rstN),
        .sw      (ldIf.lane)
    );

    // Store direction: register value to memory order
    elr_lane_swap #(
        .TO_REG (1'b0)
    ) u_store (
        .clk_sys (clk_sys),
        .rstN    (rstN),
        .sw      (stIf.lane)
    );

    assign loadValid  = ldIf.validOut;
    assign loadData   = ldIf.dataOut;
    assign storeValid = stIf.validOut;
    assign storeData  = stIf.dataOut;

    // Status shows the block's last decisions to software
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            status <= '0;
        end else begin
            status[ST_FETCH_ORDER] <= fetchValid ? fetchOrderNow : status[ST_FETCH_ORDER];
            status[ST_DATA_ORDER]  <= accValid ? accOrderNow : status[ST_DATA_ORDER];
            status[ST_MISALIGN]    <= accValid ? misNow : status[ST_MISALIGN];
            status[ST_ALIGN_FAULT] <= accValid ? (misNow && accNeedAlign)
                                               : status[ST_ALIGN_FAULT];
            status[ST_SPLIT_BUSY]  <= (accState == ACC_HELD);
        end
    end

    // Checks on the steering behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    sequence s_split_open;
        accValid && accFirst && !accLast;
    endsequence

    sequence s_next_piece;
        accValid && !accFirst;
    endsequence

    a_fetch_le_rev: assert property (fetchValid && fetchOrderNow |=>  // see RULE5
        fillWord == elr_rev4($past(fetchMemWord)))
        else $error("little-endian fetch word not reversed");

    a_fetch_be_keep: assert property (fetchValid && !fetchOrderNow |=> // see RULE6
        fillWord == $past(fetchMemWord))
        else $error("big-endian fetch word altered");

    a_fetch_word_addr: assert property (fillValid |-> fillAddr[1:0] == 2'b00) // see RULE15
        else $error("fill address not word aligned");

    a_real_map_src: assert property (accValid && accFirst && msw == 2'b00 |=> // see RULE3
        dataOrder == $past(orderMap[accAddr[REGION_MSB:REGION_LSB]]))
        else $error("real mode flag not from region map");

    a_virt_entry_src: assert property (accValid && accFirst && msw != 2'b00 |=> // see RULE2
        dataOrder == $past(accTlbOrder))
        else $error("virtual mode flag not from entry");

    a_addr_pass: assert property (accValid |=> memAddr == $past(accAddr)) // see RULE4
        else $error("access address modified");

    // Idle cycles may sit between pieces; dataOrder holds across them
    a_split_hold: assert property (s_split_open ##[1:4] s_next_piece |=> // see RULE20
        dataOrder == $past(dataOrder))
        else $error("order flag changed inside split access");

    a_byte_nomove: assert property (accValid && !accStore && sizeNow == SZ_BYTE |=> // see RULE8
        loadData == {24'h0, $past(cacheOpData[31:24])})
        else $error("byte load reordered");

    a_word_le_rev: assert property (accValid && !accStore && sizeNow == SZ_WORD // see RULE10
        && accOrderNow && !accByteRev |=> loadData == elr_rev4($past(cacheOpData)))
        else $error("little-endian word load not reversed");

    a_half_le_swap: assert property (accValid && accStore && sizeNow == SZ_HALF // see RULE9
        && accOrderNow && !accByteRev |=>
        storeData[31:16] == {$past(regStoreData[7:0]), $past(regStoreData[15:8])})
        else $error("little-endian halfword store not swapped");

    a_align_same: assert property (accValid |=> misaligned == // see RULE16
        |($past(accAddr[3:0]) & elr_align_mask($past(sizeNow))))
        else $error("alignment depends on order flag");

    a_fault_equal: assert property (accValid && misNow && accNeedAlign |=> alignFault) // see RULE17
        else $error("alignment fault missing");
endmodule // elr_top
